// ==== src/ebp_pkg.sv ====
// Package of field positions, encodings and timing constants for the bridge PWM
package ebp_pkg;
  // Control word field positions
  localparam int CFG_HI   = 7;
  localparam int CFG_LO   = 6;
  localparam int DLO_HI   = 5;
  localparam int DLO_LO   = 4;
  localparam int MODE_HI  = 3;
  localparam int MODE_LO  = 0;
  localparam int POL_AC   = 1;  // Mode bit: outputs A and C active low
  localparam int POL_BD   = 0;  // Mode bit: outputs B and D active low

  // Output configuration encodings
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_HALF   = 2'h2;
  localparam logic [1:0] CFG_FWD    = 2'h1;
  localparam logic [1:0] CFG_REV    = 2'h3;
  localparam logic [1:0] MODE_PWM   = 2'h3;  // Mode bits 3:2 select PWM

  // Prescaler select encodings (1x selects 16)
  localparam logic [1:0] PRE_DIV1 = 2'h0;
  localparam logic [1:0] PRE_DIV4 = 2'h1;

  // Widths and reset values
  localparam int         NUM_TMR  = 2;
  localparam int         FINE_W   = 6;
  localparam int         DB_W     = 7;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Oscillator period and one instruction cycle in oscillator periods
  localparam int         TOSC_NS     = 4;
  localparam int         CLK_NS      = 4;
  localparam int         INSTR_TOSC  = 4;
  localparam int         INSTR_CYC   = (INSTR_TOSC * TOSC_NS + CLK_NS - 1)
                                       / CLK_NS;
  localparam logic [1:0] Q_LAST      = 2'(INSTR_CYC - 1);

  // Last fine count of one timer tick for each prescale ratio
  localparam logic [FINE_W-1:0] FINE_LAST1  = 6'h03;
  localparam logic [FINE_W-1:0] FINE_LAST4  = 6'h0F;
  localparam logic [FINE_W-1:0] FINE_LAST16 = 6'h3F;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} ebp_state_t;
endpackage : ebp_pkg

// ==== src/ebp_pwm.sv ====
// Enhanced bridge PWM: two base timers, buffered duty, bridge steering
// Notes on behaviour
// - Configuration comes from control bits 7:6, polarity from bits 1:0.
// - Written control values take effect when the base timer resets; a direction change swaps A and C one tick before it.
// - Dead-band count loads at both the duty match and the period boundary.
// - After enable, output starts only at the next timer reset.
// - Period is (limit + 1) times four oscillator periods times prescale.
// - Timer equal to period limit clears on the next increment.
// - Modulated output sets at each period start unless duty is zero.
// - Duty writes allowed anytime; shadow copies them only at period match.
// - Postscaler changes only the timer event rate, never the PWM period.
// - Duty is ten bits: eight from duty register, two from bits 5:4.
// - Pulse width is duty times one oscillator period times prescale.
// - Shadow duty register is read only; software cannot write it.
// - Output clears when shadow plus latch equals extended timer value.
// - Duty longer than period means the output never clears.
// - Config codes: 00 single, 10 half, 01 forward, 11 reverse.
// - Forward: A active, B and C inactive, D modulated.
// - Reverse: C active, A and D inactive, B modulated.
// - Timer prescaler divides by 1, 4 or 16.
// - One of two base timers is chosen as period source.
// - Half bridge: modulated signal on A, complement on B.
// - Half bridge: each turn-on is delayed by dead-band instruction cycles.
// - Direction change: modulated outputs inactive in last tick before switch.
`timescale 1ns/10ps
module ebp_pwm (
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  input  wire logic [7:0] MODULE_CONTROL_I,
  input  wire logic [7:0] DUTY_WRITE_I,
  input  wire logic [6:0] DEADBAND_COUNT_I,
  input  wire logic       TIMER_SELECT_I,
  input  wire logic [1:0] TIMER_ON_I,
  input  wire logic [7:0] PERIOD_LIMIT_I,
  input  wire logic [7:0] ALT_PERIOD_LIMIT_I,
  input  wire logic [1:0] PRESCALE_SEL_I,
  input  wire logic [1:0] ALT_PRESCALE_SEL_I,
  input  wire logic [3:0] POSTSCALE_SEL_I,
  input  wire logic [3:0] ALT_POSTSCALE_SEL_I,
  output logic      [7:0] DUTY_SHADOW_O,
  output logic      [7:0] BASE_TIMER_O,
  output logic      [7:0] ALT_BASE_TIMER_O,
  output logic      [1:0] TIMER_EVENT_O,
  output logic            PWM_RUNNING_O,
  output logic            BRIDGE_OUT_A_O,
  output logic            BRIDGE_OUT_B_O,
  output logic            BRIDGE_OUT_C_O,
  output logic            BRIDGE_OUT_D_O
);
  import ebp_pkg::*;

  // Last fine count of a timer tick for the chosen prescale
  function automatic logic [FINE_W-1:0] fine_last(input logic [1:0] pre);
    if (pre == PRE_DIV1) begin
      fine_last = FINE_LAST1;
    end else if (pre == PRE_DIV4) begin
      fine_last = FINE_LAST4;
    end else begin
      fine_last = FINE_LAST16;
    end
  endfunction : fine_last

  // Fine position inside a tick at which the two low duty bits match
  function automatic logic [FINE_W-1:0] clr_pos(input logic [1:0] pre,
                                                input logic [1:0] lo2);
    if (pre == PRE_DIV1) begin
      clr_pos = {4'h0, lo2};
    end else if (pre == PRE_DIV4) begin
      clr_pos = {2'h0, lo2, 2'h0};
    end else begin
      clr_pos = {lo2, 4'h0};
    end
  endfunction : clr_pos

  logic [7:0]        pr_in    [NUM_TMR];
  logic [1:0]        pre_in   [NUM_TMR];
  logic [3:0]        post_in  [NUM_TMR];
  logic [FINE_W-1:0] fine     [NUM_TMR];
  logic [7:0]        tmr      [NUM_TMR];
  logic [3:0]        post_cnt [NUM_TMR];
  logic              tmr_ev   [NUM_TMR];
  logic              wrap     [NUM_TMR];

  assign pr_in[0]   = PERIOD_LIMIT_I;
  assign pr_in[1]   = ALT_PERIOD_LIMIT_I;
  assign pre_in[0]  = PRESCALE_SEL_I;
  assign pre_in[1]  = ALT_PRESCALE_SEL_I;
  assign post_in[0] = POSTSCALE_SEL_I;
  assign post_in[1] = ALT_POSTSCALE_SEL_I;

  // Two identical base timers; the fine count spans one prescaled tick
  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      assign wrap[g] = TIMER_ON_I[g] && (fine[g] == fine_last(pre_in[g]))
                       && (tmr[g] == pr_in[g]);
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          fine[g]     <= '0;
          tmr[g]      <= RST_BYTE;
          post_cnt[g] <= 4'h0;
          tmr_ev[g]   <= 1'b0;
        end else begin
          tmr_ev[g] <= 1'b0;
          if (TIMER_ON_I[g]) begin
            if (fine[g] == fine_last(pre_in[g])) begin
              fine[g] <= '0;
              if (tmr[g] == pr_in[g]) begin
                tmr[g] <= RST_BYTE;
                // Postscaler only paces the event, not the period
                if (post_cnt[g] == post_in[g]) begin
                  post_cnt[g] <= 4'h0;
                  tmr_ev[g]   <= 1'b1;
                end else begin
                  post_cnt[g] <= post_cnt[g] + 4'h1;
                end
              end else begin
                tmr[g] <= tmr[g] + 8'h01;
              end
            end else begin
              fine[g] <= fine[g] + 6'h01;
            end
          end
        end
      end
    end
  endgenerate

  assign BASE_TIMER_O     = tmr[0];
  assign ALT_BASE_TIMER_O = tmr[1];
  assign TIMER_EVENT_O    = {tmr_ev[1], tmr_ev[0]};

  // Period source selection
  logic              sel;
  logic [FINE_W-1:0] s_fine;
  logic [7:0]        s_tmr;
  logic [7:0]        s_pr;
  logic [1:0]        s_pre;
  logic              boundary;
  logic              last_tick;

  assign sel       = TIMER_SELECT_I;
  assign s_fine    = fine[sel];
  assign s_tmr     = tmr[sel];
  assign s_pr      = pr_in[sel];
  assign s_pre     = pre_in[sel];
  assign boundary  = wrap[sel];
  assign last_tick = TIMER_ON_I[sel] && (s_tmr == s_pr);

  // Written control fields
  logic [1:0] wr_cfg;
  logic [3:0] wr_mode;
  logic [1:0] wr_lo2;
  logic       wr_pwm;

  assign wr_cfg  = MODULE_CONTROL_I[CFG_HI:CFG_LO];
  assign wr_mode = MODULE_CONTROL_I[MODE_HI:MODE_LO];
  assign wr_lo2  = MODULE_CONTROL_I[DLO_HI:DLO_LO];
  assign wr_pwm  = (wr_mode[3:2] == MODE_PWM);

  // Enable waits for a timer reset so the first period is whole
  ebp_state_t state;
  logic       next_run;

  assign next_run = wr_pwm && (state != ST_IDLE);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state         <= ST_IDLE;
      PWM_RUNNING_O <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (wr_pwm) begin
            state <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (!wr_pwm) begin
            state <= ST_IDLE;
          end else if (boundary) begin
            state         <= ST_RUN;
            PWM_RUNNING_O <= 1'b1;
          end
        end
        ST_RUN: begin
          if (boundary && !wr_pwm) begin
            state         <= ST_IDLE;
            PWM_RUNNING_O <= 1'b0;
          end
        end
        default: begin
          state         <= ST_IDLE;
          PWM_RUNNING_O <= 1'b0;
        end
      endcase
    end
  end

  // Active copies load only at the period boundary to avoid glitches
  logic [1:0] act_cfg;
  logic [3:0] act_mode;
  logic [1:0] duty_lo2;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      act_cfg       <= CFG_SINGLE;
      act_mode      <= 4'h0;
      DUTY_SHADOW_O <= RST_BYTE;
      duty_lo2      <= 2'h0;
    end else if (boundary) begin
      act_cfg       <= wr_cfg;
      act_mode      <= wr_mode;
      DUTY_SHADOW_O <= DUTY_WRITE_I;
      duty_lo2      <= wr_lo2;
    end
  end

  // Extended timer compare; duty beyond the period never matches
  logic clr_hit;
  logic in_run;

  assign in_run  = (state == ST_RUN);
  // Match on the count about to start, so high time is exactly the duty
  assign clr_hit = (s_fine == fine_last(s_pre))
                   ? (((s_tmr + 8'h01) == DUTY_SHADOW_O)
                      && (clr_pos(s_pre, duty_lo2) == '0))
                   : ((s_tmr == DUTY_SHADOW_O)
                      && ((s_fine + 6'h01) == clr_pos(s_pre, duty_lo2)));

  // Modulated signal: set at period start, cleared at the duty match
  logic mod;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mod <= 1'b0;
    end else if (boundary && next_run) begin
      mod <= ({DUTY_WRITE_I, wr_lo2} != 10'h000);
    end else if (!in_run || clr_hit) begin
      mod <= 1'b0;
    end
  end

  // Dead-band count loads on duty match or period boundary
  logic [DB_W-1:0] db_act;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      db_act <= '0;
    end else if (boundary || (in_run && clr_hit)) begin
      db_act <= DEADBAND_COUNT_I;
    end
  end

  // Instruction cycle enable for dead-band counting
  logic [1:0] q_cnt;
  logic       instr_en;

  assign instr_en = (q_cnt == Q_LAST);

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      q_cnt <= 2'h0;
    end else begin
      q_cnt <= q_cnt + 2'h1;
    end
  end

  // Turn-on delay per half-bridge leg; the first decrement may be partial
  logic            half;
  logic            raw    [2];
  logic            raw_q  [2];
  logic [DB_W-1:0] db_cnt [2];
  logic            db_ok  [2];

  assign half   = in_run && (act_cfg == CFG_HALF);
  assign raw[0] = half && mod;
  assign raw[1] = half && !mod;

  generate
    for (g = 0; g < 2; g++) begin : g_db
      assign db_ok[g] = raw[g] && (db_cnt[g] == '0)
                        && !(!raw_q[g] && (db_act != '0));
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          raw_q[g]  <= 1'b0;
          db_cnt[g] <= '0;
        end else begin
          raw_q[g] <= raw[g];
          if (raw[g] && !raw_q[g]) begin
            // The current instruction tick already counts as one step
            db_cnt[g] <= (instr_en && (db_act != '0)) ? db_act - 7'h01
                                                       : db_act;
          end else if (!raw[g]) begin
            db_cnt[g] <= '0;
          end else if (instr_en && (db_cnt[g] != '0)) begin
            db_cnt[g] <= db_cnt[g] - 7'h01;
          end
        end
      end
    end
  endgenerate

  // Pending full-bridge direction change
  logic dir_chg;

  assign dir_chg = in_run && wr_pwm && act_cfg[0] && wr_cfg[0]
                   && (wr_cfg != act_cfg);

  // Output steering in active-level terms, 1 meaning active
  logic [3:0] lvl;

  always_comb begin
    lvl = 4'h0;
    if (in_run) begin
      if (dir_chg && last_tick) begin
        // Modulated legs blank while the fixed legs swap sides
        lvl = {1'b0, (wr_cfg == CFG_REV), 1'b0,
               (wr_cfg == CFG_FWD)};
      end else begin
        case (act_cfg)
          CFG_SINGLE: lvl = {3'h0, mod};
          CFG_HALF:   lvl = {2'h0, db_ok[1], db_ok[0]};
          CFG_FWD:    lvl = {mod, 2'h0, 1'b1};
          CFG_REV:    lvl = {1'b0, 1'b1, mod, 1'b0};
          default:    lvl = 4'h0;
        endcase
      end
    end
  end

  // Pins registered with polarity applied
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      BRIDGE_OUT_A_O <= 1'b0;
      BRIDGE_OUT_B_O <= 1'b0;
      BRIDGE_OUT_C_O <= 1'b0;
      BRIDGE_OUT_D_O <= 1'b0;
    end else begin
      BRIDGE_OUT_A_O <= lvl[0] ^ act_mode[POL_AC];
      BRIDGE_OUT_B_O <= lvl[1] ^ act_mode[POL_BD];
      BRIDGE_OUT_C_O <= lvl[2] ^ act_mode[POL_AC];
      BRIDGE_OUT_D_O <= lvl[3] ^ act_mode[POL_BD];
    end
  end

  // Checks
  sequence s_bound;
    boundary && next_run;
  endsequence

  a_timer_wrap: assert property (@(posedge CLK_I) disable iff (RST_I)
    wrap[0] |=> (tmr[0] == 8'h00) && (fine[0] == '0))
    else $error("timer did not clear after period match");

  a_shadow_load: assert property (@(posedge CLK_I) disable iff (RST_I)
    boundary |=> (DUTY_SHADOW_O == $past(DUTY_WRITE_I)))
    else $error("shadow duty not loaded at period match");

  a_shadow_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !boundary |=> $stable(DUTY_SHADOW_O) && $stable(act_cfg))
    else $error("buffered value changed off boundary");

  a_zero_duty: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_bound and ({DUTY_WRITE_I, wr_lo2} == 10'h000) |=> !mod)
    else $error("output set with zero duty");

  a_period_set: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_bound and ({DUTY_WRITE_I, wr_lo2} != 10'h000) |=> mod)
    else $error("output not set at period start");

  a_duty_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
    in_run && clr_hit && !boundary |=> !mod)
    else $error("output not cleared at duty match");

  a_arm_wait: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state == ST_ARMED) && !boundary |=> (state != ST_RUN) && !mod)
    else $error("output started before timer reset");

  a_fwd_drive: assert property (@(posedge CLK_I) disable iff (RST_I)
    in_run && (act_cfg == CFG_FWD) && !(dir_chg && last_tick)
    |=> (BRIDGE_OUT_A_O == !$past(act_mode[POL_AC]))
        && (BRIDGE_OUT_D_O == ($past(mod) ^ $past(act_mode[POL_BD]))))
    else $error("forward bridge outputs wrong");

  a_rev_drive: assert property (@(posedge CLK_I) disable iff (RST_I)
    in_run && (act_cfg == CFG_REV) && !(dir_chg && last_tick)
    |=> (BRIDGE_OUT_C_O == !$past(act_mode[POL_AC]))
        && (BRIDGE_OUT_B_O == ($past(mod) ^ $past(act_mode[POL_BD]))))
    else $error("reverse bridge outputs wrong");

  a_dir_blank: assert property (@(posedge CLK_I) disable iff (RST_I)
    dir_chg && last_tick
    |=> (BRIDGE_OUT_B_O == $past(act_mode[POL_BD]))
        && (BRIDGE_OUT_D_O == $past(act_mode[POL_BD])))
    else $error("modulated leg active during direction change");

  a_half_gap: assert property (@(posedge CLK_I) disable iff (RST_I)
    half && $rose(mod) && (db_act != '0) |=> !lvl[0] ##1 !lvl[0])
    else $error("half bridge turn-on not delayed");
endmodule : ebp_pwm

// ==== verif/ebp_bridge_model.sv ====
// Power switch driver model: flags any bridge leg with both switches on
`timescale 1ns/10ps
module ebp_bridge_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] pins_i,     // Pin levels as {D, C, B, A}
  input  wire logic [3:0] act_low_i,  // Driver input polarity per pin
  output int              shoot_o
);
  logic [3:0] on;

  // Pin levels are flipped by the driver polarity, so 1 means the switch is on
  assign on = pins_i ^ act_low_i;

  // Legs are A over B and C over D; overlap would short the supply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shoot_o <= 0;
    end else if ((on[0] && on[1]) || (on[2] && on[3])) begin
      shoot_o <= shoot_o + 1;
    end
  end
endmodule : ebp_bridge_model

// ==== verif/enhanced_bridge_pwm_tb.sv ====
// Self-checking bench for the bridge PWM with a switch driver model
`timescale 1ns/10ps
module enhanced_bridge_pwm_tb;
  import ebp_pkg::*;
  logic       clk, rst, tsel, running, pa, pb, pc, pd;
  logic [7:0] ctrl, duty, lim, alt_lim, shadow, tmr, alt_tmr, rnd;
  logic [6:0] db;
  logic [1:0] ton, pre, alt_pre, evt;
  logic [3:0] post, alt_post, actlow;
  int         shoot, bad_count, checked, cycles, cnt[4];
  int         k, p, sc, hi, per, d, s0, lo;

  ebp_pwm DUT (.CLK_I(clk), .RST_I(rst), .MODULE_CONTROL_I(ctrl),
    .DUTY_WRITE_I(duty), .DEADBAND_COUNT_I(db), .TIMER_SELECT_I(tsel),
    .TIMER_ON_I(ton), .PERIOD_LIMIT_I(lim), .ALT_PERIOD_LIMIT_I(alt_lim),
    .PRESCALE_SEL_I(pre), .ALT_PRESCALE_SEL_I(alt_pre),
    .POSTSCALE_SEL_I(post), .ALT_POSTSCALE_SEL_I(alt_post),
    .DUTY_SHADOW_O(shadow), .BASE_TIMER_O(tmr), .ALT_BASE_TIMER_O(alt_tmr),
    .TIMER_EVENT_O(evt), .PWM_RUNNING_O(running), .BRIDGE_OUT_A_O(pa),
    .BRIDGE_OUT_B_O(pb), .BRIDGE_OUT_C_O(pc), .BRIDGE_OUT_D_O(pd));

  ebp_bridge_model MODEL (.clk_i(clk), .rst_i(rst), .pins_i({pd, pc, pb, pa}),
    .act_low_i(actlow), .shoot_o(shoot));

  // Free-running 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, sized well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      end_of_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  function automatic int scale(input logic [1:0] s);
    return (s == PRE_DIV1) ? 1 : ((s == PRE_DIV4) ? 4 : 16);
  endfunction : scale

  // Pin level normalised so that 1 means active
  function automatic logic act(input int i);
    logic [3:0] v;
    v = {pd, pc, pb, pa} ^ actlow;
    return v[i];
  endfunction : act

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Control word and duty change together, just after an edge
  task automatic setup(input logic [1:0] cfg, input logic [9:0] d10,
                       input logic [3:0] mode);
    @(posedge clk);
    #1;
    ctrl = {cfg, d10[1:0], mode};
    duty = d10[9:2];
  endtask : setup

  // Rise to rise on one pin: active cycles and period length
  task automatic measure(input int i, output int h, output int pr);
    logic prev, cur;
    int   n;
    h = 0;
    pr = 0;
    n = 0;
    cur = act(i);
    do begin
      prev = cur;
      @(negedge clk);
      cur = act(i);
      n++;
    end while (!(cur === 1'b1 && prev === 1'b0) && n < 4000);
    do begin
      h += int'(cur === 1'b1);
      pr++;
      prev = cur;
      @(negedge clk);
      cur = act(i);
      n++;
    end while (!(cur === 1'b1 && prev === 1'b0) && n < 8000);
  endtask : measure

  // Active cycles of every pin over a window
  task automatic count(input int n);
    cnt = '{0, 0, 0, 0};
    repeat (n) begin
      @(negedge clk);
      for (int j = 0; j < 4; j++) cnt[j] += int'(act(j) === 1'b1);
    end
  endtask : count

  initial begin
    rst = 1'b1; ctrl = 8'h00; duty = 8'h00; db = 7'h00; tsel = 1'b0;
    ton = 2'h0; lim = 8'h00; alt_lim = 8'h00; pre = 2'h0; alt_pre = 2'h0;
    post = 4'h0; alt_post = 4'h0; actlow = 4'h0; rnd = 8'h17;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    // Random single-output periods over both timers and all prescales
    for (k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      #1;
      // Reset restarts both timers so a smaller limit is not overrun
      rst = 1'b1;
      pre = 2'(k % 3); alt_pre = 2'((k + 1) % 3); tsel = k[0];
      lim = {4'h0, rnd[3:0]}; alt_lim = {4'h0, rnd[7:4]};
      post = rnd[3:0]; alt_post = rnd[7:4];
      p = ((tsel ? alt_lim : lim) + 1) * 4;
      sc = scale(tsel ? alt_pre : pre);
      rnd = lfsr(rnd);
      d = 1 + (rnd % (p - 1));
      @(posedge clk);
      #1 rst = 1'b0;
      setup(CFG_SINGLE, 10'(d), {MODE_PWM, 2'h0});
      if (k == 0) begin
        ton = 2'h3;
        @(negedge clk);
        check(32'(running), 32'h0);
      end
      measure(0, hi, per);
      measure(0, hi, per);
      check(per, p * sc);
      check(hi, d * sc);
    end
    // Zero duty and duty beyond the period, 16-cycle period
    @(posedge clk);
    #1;
    rst = 1'b1;
    tsel = 1'b0; pre = PRE_DIV1; lim = 8'h03; post = 4'h1;
    @(posedge clk);
    #1 rst = 1'b0;
    setup(CFG_SINGLE, 10'h000, {MODE_PWM, 2'h0});
    repeat (40) @(negedge clk);
    count(32);
    check(cnt[0], 0);
    // Event every second wrap of a 16-cycle period; timer stays in range
    s0 = 0;
    hi = 0;
    repeat (64) begin
      @(negedge clk);
      s0 += int'(evt[0] === 1'b1);
      hi += int'(tmr > lim);
    end
    check(s0, 2);
    check(hi, 0);
    setup(CFG_SINGLE, 10'h040, {MODE_PWM, 2'h0});
    repeat (40) @(negedge clk);
    count(32);
    check(cnt[0], 32);
    // Mid-period duty write stays out of the shadow until the wrap
    setup(CFG_SINGLE, 10'h008, {MODE_PWM, 2'h0});
    measure(0, hi, per);
    measure(0, hi, per);
    setup(CFG_SINGLE, 10'h004, {MODE_PWM, 2'h0});
    @(negedge clk);
    check(32'(shadow), 32'h02);
    measure(0, hi, per);
    check(32'(shadow), 32'h01);
    check(hi, 4);
    // Direction changes at near-full duty must not overlap a leg
    s0 = shoot;
    for (k = 0; k < 3; k++) begin
      setup(k[0] ? CFG_REV : CFG_FWD, 10'h00F, {MODE_PWM, 2'h0});
      measure(k[0] ? 1 : 3, hi, per);
      measure(k[0] ? 1 : 3, hi, per);
      count(16);
      for (int j = 0; j < 4; j++) begin
        lo = (j == (k[0] ? 2 : 0)) ? 16 : ((j == (k[0] ? 1 : 3)) ? 15 : 0);
        check(cnt[j], lo);
      end
    end
    check(shoot - s0, 0);
    // Half bridge with and without dead band, 32-cycle period
    @(posedge clk);
    #1 lim = 8'h07;
    for (k = 0; k < 2; k++) begin
      db = 7'(2 * k);
      s0 = shoot;
      setup(CFG_HALF, 10'h010, {MODE_PWM, 2'h0});
      measure(0, hi, per);
      measure(0, hi, per);
      lo = 16 - 4 * int'(db);
      check(32'(hi >= lo && hi <= lo + 3), 32'h1);
      measure(1, hi, per);
      check(32'(hi >= lo && hi <= lo + 3), 32'h1);
      check(shoot - s0, 0);
    end
    // Active-low outputs: pin A low for the duty time
    db = 7'h00;
    setup(CFG_SINGLE, 10'h008, 4'hF);
    actlow = 4'hF;
    measure(0, hi, per);
    measure(0, hi, per);
    check(hi, 8);
    check(per, 32);
    end_of_test();
  end
endmodule : enhanced_bridge_pwm_tb
